// ===== hw/cfc_pkg.sv
// constants and field layouts of the channel block
package cfc_pkg;
    // register map, byte offsets
    localparam logic [7:0] OFS_ARB_TIMING = 8'h00;
    localparam logic [7:0] OFS_CHAN_CFG   = 8'h04;
    localparam logic [7:0] OFS_MODE       = 8'h08;
    localparam logic [7:0] OFS_TXQ_CFG    = 8'h0c;
    localparam logic [7:0] OFS_THL_CFG    = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
    localparam logic [7:0] OFS_ERR_COUNT  = 8'h1c;
    localparam logic [7:0] OFS_BIT_STAT   = 8'h20;

    // arbitration timing, each field stored as value minus one
    typedef struct packed {
        logic [3:0] sjw;
        logic [3:0] tseg2;
        logic [1:0] rsvA;
        logic [5:0] tseg1;
        logic [5:0] rsvB;
        logic [9:0] brp;
    } cfc_timing_type;
    localparam cfc_timing_type TIMING_RESET = 32'h0001_0000;

    typedef struct packed {
        logic [9:0] rsv;
        logic [2:0] eocScope;
        logic [1:0] bom;
        logic [1:0] testMode;
        logic [6:0] tdcOffset;
        logic       tdcMeas;
        logic       tdcEn;
        logic       gwBrs;
        logic       gwFdf;
        logic       multiGw;
        logic       esiByBuf;
        logic       edgeFilt;
        logic       fdOnly;
    } cfc_chan_type;
    localparam cfc_chan_type CHAN_RESET = 32'h0000_0000;

    // per queue control byte
    typedef struct packed {
        logic [1:0] rsv;
        logic       oneRxIe;
        logic       fullIe;
        logic       intOnLast;
        logic       irqEn;
        logic       gwEn;
        logic       qEn;
    } cfc_txq_type;

    typedef enum { MODE_INIT, MODE_HALT, MODE_OPER } cfc_mode_type;
    localparam logic [1:0] MODE_CODE_INIT = 2'h0;
    localparam logic [1:0] MODE_CODE_HALT = 2'h1;
    localparam logic [1:0] MODE_CODE_OPER = 2'h2;
    localparam int         MODE_ERR_BIT   = 2;

    localparam logic [1:0] TEST_NONE   = 2'h0;
    localparam logic [1:0] TEST_LISTEN = 2'h1;
    localparam logic [1:0] TEST_EXTLP  = 2'h2;
    localparam logic [1:0] TEST_INTLP  = 2'h3;

    localparam logic [1:0] BOM_PROTO      = 2'h0;
    localparam logic [1:0] BOM_HALT_BEFORE = 2'h1;
    localparam logic [1:0] BOM_HALT_AFTER = 2'h2;
    localparam logic [1:0] BOM_SOFTWARE   = 2'h3;

    localparam logic [2:0] EOC_ALL   = 3'h0;
    localparam logic [2:0] EOC_TX    = 3'h1;
    localparam logic [2:0] EOC_RX    = 3'h2;
    localparam logic [2:0] EOC_ALLFD = 3'h3;
    localparam logic [2:0] EOC_TXFD  = 3'h4;
    localparam logic [2:0] EOC_RXFD  = 3'h5;

    // interrupt status layout
    localparam int NUM_CHAN_EV = 12;
    localparam int NUM_TXQ     = 4;
    localparam int NUM_GW_TXQ  = 3;
    localparam int IRQ_TXQ_LSB = 12;
    localparam int IRQ_THL_BIT = 16;
    localparam int IRQ_W       = 17;
    localparam int EV_ERRCOVF  = 9;

    // transmit history
    localparam logic [5:0] THL_DEPTH = 6'h20;
    localparam logic [5:0] THL_LEVEL = 6'h18;

    // timing figures
    localparam longint CLK_HZ      = 250000000;
    localparam longint ARB_MAX_BPS = 1000000;
    localparam longint DAT_MAX_BPS = 20000000;
    localparam logic [16:0] MIN_ARB_CYCLES = 17'(CLK_HZ / ARB_MAX_BPS);
    localparam logic [1:0]  FILTER_TQ      = 2'h2;
endpackage

// ===== hw/cfc_channel_cfg.sv
// configuration, mode, timing and interrupt logic of one can-fd channel
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - timing fields act as stored value plus one
// - timing field ranges; segment one zero refused
// - edge filter ignores dominant glitches under 2 quanta
// - fd-exclusive flags and refuses classic frames
// - queue irq per send or on empty
// - history irq per entry or three quarters
// - history logs all or only queued sources
// - gateway enables only queues 0-2, need gateway
// - esi from node state or active buffer
// - multi-gateway converts to classic or fd
// - converted brs needs brs and fd output
// - tdc off, offset, or measured plus offset
// - listen-only, external and internal loopback modes
// - bus-off recovery: protocol, halt before/after, software
// - twelve individually masked channel events
// - error counting scope all/tx/rx, optional fd
// - arbitration rate at most 1 Mbit/s for written timing; reset timing runs 4 clocks a bit
module cfc_channel_cfg
    import cfc_pkg::*;
(
    input  wire logic                   clock, // clock
    input  wire logic                   sys_rst, // sync reset, high
    input  wire logic                   clkEn, // run enable
    input  wire logic [7:0]             regAddr, // byte address
    input  wire logic [31:0]            regWrData, // write data
    input  wire logic                   regWrStb, // write strobe
    input  wire logic                   regRdStb, // read strobe
    output logic      [31:0]            regRdData, // read data
    output logic                        irq, // level irq
    input  wire logic                   canRx, // from transceiver
    output logic                        canTx, // to transceiver
    input  wire logic                   coreTx, // core tx bit
    output logic                        coreRx, // rx seen by core
    input  wire logic                   busIdle, // intermission
    output logic                        tqTick, // quantum tick
    output logic                        hardSync, // hard sync
    output logic                        samplePoint, // sample point
    input  wire logic                   rxFrameDone, // frame received
    input  wire logic                   rxFrameFd, // frame was fd
    output logic                        rxFormatErr, // classic in fd-only
    input  wire logic                   txReqClassic, // classic send
    output logic                        txRefuse, // refused
    input  wire logic                   nodePassive, // error passive
    input  wire logic                   bufEsi, // buffer esi
    output logic                        esiOut, // esi to send
    input  wire logic                   gwInFd, // gateway in fd
    input  wire logic                   gwInBrs, // gateway in brs
    output logic                        gwOutFd, // forwarded fd
    output logic                        gwOutBrs, // forwarded brs
    input  wire logic [6:0]             tdcMeasured, // measured delay
    output logic                        tdcActive, // tdc on
    output logic      [7:0]             tdcPosition, // tdc point
    output logic                        listenOnly, // no ack, no tx
    output logic                        protoRecovEn, // protocol recovery
    output logic      [1:0]             modeState, // mode code
    input  wire logic                   busOffEv, // bus off
    input  wire logic                   recovDoneEv, // recovery done
    input  wire logic [NUM_CHAN_EV-1:0] chanEv, // channel events
    input  wire logic                   errEv, // protocol error
    input  wire logic                   errIsTx, // while sending
    input  wire logic                   errIsFd, // fd frame
    input  wire logic [NUM_TXQ-1:0]     txqSent, // queue sent
    input  wire logic [NUM_TXQ-1:0]     txqEmpty, // queue empty
    input  wire logic [NUM_TXQ-1:0]     txqFullEv, // queue full
    input  wire logic [NUM_TXQ-1:0]     txqOneRxEv, // queue got one
    input  wire logic                   thlWrite, // history candidate
    input  wire logic                   thlFromQueue, // from fifo/queue
    input  wire logic                   thlPop // entry taken
);
    cfc_timing_type timing_q;
    cfc_chan_type   chan_q;
    cfc_txq_type [NUM_TXQ-1:0] txq_q;
    logic [3:0]       thl_q;
    cfc_mode_type     mode_q;
    cfc_mode_type     mode_d;
    logic             cfgErr_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] evVec;
    logic [7:0]       errCnt_q;
    logic [5:0]       thlCnt_q;
    logic [9:0]       preCnt_q;
    logic [6:0]       bitCnt_q;
    logic [1:0]       filtCnt_q;
    logic             canRx_q;
    logic [31:0]      rdData_q;

    // address decode
    wire wrTiming = regWrStb && regAddr == OFS_ARB_TIMING;
    wire wrChan   = regWrStb && regAddr == OFS_CHAN_CFG;
    wire wrMode   = regWrStb && regAddr == OFS_MODE;
    wire wrTxq    = regWrStb && regAddr == OFS_TXQ_CFG;
    wire wrThl    = regWrStb && regAddr == OFS_THL_CFG;
    wire wrStat   = regWrStb && regAddr == OFS_IRQ_STAT;
    wire wrMask   = regWrStb && regAddr == OFS_IRQ_MASK;
    wire wrErrCnt = regWrStb && regAddr == OFS_ERR_COUNT;
    wire wrCfg    = wrTiming | wrChan | wrTxq | wrThl;
    wire inInit   = mode_q == MODE_INIT;

    // proposed timing checked before it is taken
    cfc_timing_type newTiming;
    assign newTiming = cfc_timing_type'(regWrData);
    wire [6:0]  newBitLen = 7'd3 + 7'(newTiming.tseg1) + 7'(newTiming.tseg2);
    wire [16:0] newBitClk = 17'(({7'h00, newTiming.brp} + 17'h1) * {10'h000, newBitLen});
    wire timingBad = newTiming.tseg1 == 6'h00
                   || newBitClk < MIN_ARB_CYCLES;
    // refused: outside init, or impossible timing
    wire cfgReject = (wrCfg && !inInit) || (wrTiming && inInit && timingBad);
    wire cfgTake   = inInit && !cfgReject;

    // configuration, taken only in init; irq mask taken in any mode
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timing_q <= TIMING_RESET;
            chan_q   <= CHAN_RESET;
            txq_q    <= '0;
            thl_q    <= '0;
            mask_q   <= '0;
        end else if (clkEn) begin
            if (wrTiming && cfgTake) timing_q <= newTiming;
            if (wrChan && cfgTake) chan_q <= cfc_chan_type'(regWrData);
            if (wrTxq && cfgTake) txq_q <= regWrData;
            if (wrThl && cfgTake) thl_q <= regWrData[3:0];
            if (wrMask) mask_q <= regWrData[IRQ_W-1:0];
        end
    end

    // sticky error; a new refusal beats the clear
    always_ff @(posedge clock) begin
        if (sys_rst) cfgErr_q <= 1'b0;
        else if (clkEn) cfgErr_q <= cfgReject | (cfgErr_q & ~(wrMode & regWrData[MODE_ERR_BIT]));
    end

    // mode control; bus-off may force halt by itself
    wire [1:0] reqCode = regWrData[1:0];
    always_comb begin
        mode_d = mode_q;
        if (wrMode) begin
            unique case (reqCode)
                MODE_CODE_INIT: mode_d = MODE_INIT;
                MODE_CODE_HALT: mode_d = MODE_HALT;
                MODE_CODE_OPER: mode_d = MODE_OPER;
                default:        mode_d = mode_q;
            endcase
        end
        if (mode_q == MODE_OPER && busOffEv && chan_q.bom == BOM_HALT_BEFORE) mode_d = MODE_HALT;
        if (mode_q == MODE_OPER && recovDoneEv && chan_q.bom == BOM_HALT_AFTER) mode_d = MODE_HALT;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) mode_q <= MODE_INIT;
        else if (clkEn) mode_q <= mode_d;
    end
    always_comb begin
        unique case (mode_q)
            MODE_INIT: modeState = MODE_CODE_INIT;
            MODE_HALT: modeState = MODE_CODE_HALT;
            MODE_OPER: modeState = MODE_CODE_OPER;
        endcase
    end
    // software recovery skips the protocol's own recovery phase
    assign protoRecovEn = chan_q.bom != BOM_SOFTWARE;

    // quantum prescaler, runs free so the filter works in intermission
    wire preWrap = preCnt_q >= timing_q.brp;
    assign tqTick = preWrap;
    always_ff @(posedge clock) begin
        if (sys_rst) preCnt_q <= '0;
        else if (clkEn) preCnt_q <= preWrap ? 10'h000 : preCnt_q + 10'h001;
    end

    // receive edge filter and hard sync
    wire rxFall = canRx_q && !canRx && busIdle;
    wire filtHit = filtCnt_q == FILTER_TQ - 2'h1 && tqTick && !canRx && busIdle;
    assign hardSync = chan_q.edgeFilt ? filtHit : rxFall;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            canRx_q   <= 1'b1;
            filtCnt_q <= '0;
        end else if (clkEn) begin
            canRx_q <= canRx;
            // a recessive level restarts the glitch count
            if (canRx || !busIdle) filtCnt_q <= '0;
            else if (tqTick && filtCnt_q != FILTER_TQ) filtCnt_q <= filtCnt_q + 2'h1;
        end
    end

    // bit position in quanta: sync, segment one, segment two
    wire [6:0] bitLen = 7'd3 + 7'(timing_q.tseg1) + 7'(timing_q.tseg2);
    wire [6:0] spPos  = 7'd2 + 7'(timing_q.tseg1);
    assign samplePoint = tqTick && bitCnt_q == spPos - 7'd1;
    always_ff @(posedge clock) begin
        if (sys_rst) bitCnt_q <= '0;
        else if (clkEn) begin
            if (hardSync) bitCnt_q <= 7'd1;
            else if (tqTick) bitCnt_q <= (bitCnt_q >= bitLen - 7'd1) ? 7'd0 : bitCnt_q + 7'd1;
        end
    end

    // frame format policing
    assign rxFormatErr = rxFrameDone && !rxFrameFd && chan_q.fdOnly;
    assign txRefuse    = txReqClassic && chan_q.fdOnly;

    // error state indicator source
    assign esiOut = chan_q.esiByBuf && !nodePassive ? bufEsi : nodePassive;

    // gateway format conversion; brs only makes sense in fd output
    assign gwOutFd  = chan_q.multiGw ? chan_q.gwFdf : gwInFd;
    assign gwOutBrs = chan_q.multiGw ? chan_q.gwBrs & chan_q.gwFdf : gwInBrs;

    // delay compensation
    assign tdcActive   = chan_q.tdcEn;
    assign tdcPosition = !chan_q.tdcEn ? 8'h00
                       : chan_q.tdcMeas ? {1'b0, tdcMeasured} + {1'b0, chan_q.tdcOffset}
                       : {1'b0, chan_q.tdcOffset};

    // test modes; internal loop keeps the bus recessive
    assign listenOnly = chan_q.testMode == TEST_LISTEN;
    wire intLoop = chan_q.testMode == TEST_INTLP;
    assign canTx  = (listenOnly || intLoop) ? 1'b1 : coreTx;
    assign coreRx = intLoop ? coreTx : canRx;

    // error counter with scope select
    logic scopeHit;
    always_comb begin
        unique case (chan_q.eocScope)
            EOC_ALL:   scopeHit = 1'b1;
            EOC_TX:    scopeHit = errIsTx;
            EOC_RX:    scopeHit = !errIsTx;
            EOC_ALLFD: scopeHit = errIsFd;
            EOC_TXFD:  scopeHit = errIsTx && errIsFd;
            EOC_RXFD:  scopeHit = !errIsTx && errIsFd;
            default:   scopeHit = 1'b0;
        endcase
    end
    wire errCount = errEv && scopeHit;
    wire errOvf   = errCount && errCnt_q == 8'hff;
    always_ff @(posedge clock) begin
        if (sys_rst) errCnt_q <= '0;
        else if (clkEn) begin
            if (wrErrCnt) errCnt_q <= '0;
            else if (errCount) errCnt_q <= errCnt_q + 8'h01;
        end
    end

    // queue events; gateway only on low queues
    logic [NUM_TXQ-1:0] txqEv;
    for (genvar i = 0; i < NUM_TXQ; i++) begin : g_txq
        wire sendEv = txqSent[i] && (!txq_q[i].intOnLast || txqEmpty[i]);
        wire gwOk   = i < NUM_GW_TXQ && txq_q[i].gwEn;
        wire gwEv   = gwOk && (txq_q[i].fullIe && txqFullEv[i]
                            || txq_q[i].oneRxIe && txqOneRxEv[i]);
        assign txqEv[i] = txq_q[i].qEn && (txq_q[i].irqEn && sendEv || gwEv);
    end

    // transmit history: bit0 enable, 1 irq enable, 2 level mode, 3 queued only
    wire thlLog  = thl_q[0] && thlWrite && (!thl_q[3] || thlFromQueue)
                 && thlCnt_q != THL_DEPTH;
    wire thlPopOk = thlPop && thlCnt_q != 6'h00;
    wire thlEv   = thl_q[1] && thlLog && (!thl_q[2] || thlCnt_q + 6'h01 == THL_LEVEL);
    always_ff @(posedge clock) begin
        if (sys_rst) thlCnt_q <= '0;
        else if (clkEn) begin
            if (thlLog && !thlPopOk) thlCnt_q <= thlCnt_q + 6'h01;
            else if (thlPopOk && !thlLog) thlCnt_q <= thlCnt_q - 6'h01;
        end
    end

    // sticky w1c status; a new event beats the clear
    always_comb begin
        evVec = '0;
        evVec[NUM_CHAN_EV-1:0] = chanEv;
        evVec[EV_ERRCOVF] = chanEv[EV_ERRCOVF] | errOvf;
        evVec[IRQ_TXQ_LSB +: NUM_TXQ] = txqEv;
        evVec[IRQ_THL_BIT] = thlEv;
    end
    wire [IRQ_W-1:0] clrVec = wrStat ? regWrData[IRQ_W-1:0] : '0;
    always_ff @(posedge clock) begin
        if (sys_rst) stat_q <= '0;
        else if (clkEn) stat_q <= evVec | (stat_q & ~clrVec);
    end
    assign irq = |(stat_q & mask_q);

    // read mux; unmapped addresses read zero
    logic [31:0] rdMux;
    always_comb begin
        unique case (regAddr)
            OFS_ARB_TIMING: rdMux = timing_q;
            OFS_CHAN_CFG:   rdMux = chan_q;
            OFS_MODE:       rdMux = {29'h0, cfgErr_q, modeState};
            OFS_TXQ_CFG:    rdMux = txq_q;
            OFS_THL_CFG:    rdMux = {20'h0, 2'h0, thlCnt_q, thl_q};
            OFS_IRQ_STAT:   rdMux = 32'(stat_q);
            OFS_IRQ_MASK:   rdMux = 32'(mask_q);
            OFS_ERR_COUNT:  rdMux = {24'h0, errCnt_q};
            OFS_BIT_STAT:   rdMux = {18'h0, bitCnt_q, bitLen};
            default:        rdMux = 32'h0;
        endcase
    end
    // data stands one cycle, else zero
    always_ff @(posedge clock) begin
        if (sys_rst) rdData_q <= '0;
        else if (clkEn) rdData_q <= regRdStb ? rdMux : 32'h0;
    end
    assign regRdData = rdData_q;
endmodule // cfc_channel_cfg

// ===== test/cfc_channel_cfg_properties.sv
// port checks of the channel configuration block
`timescale 1ns/1ps
module cfc_channel_cfg_properties (
    input wire logic       clock, // clock
    input wire logic       sys_rst, // sync reset
    input wire logic       canRx, // bus level
    input wire logic       canTx, // to transceiver
    input wire logic       coreTx, // core tx bit
    input wire logic       coreRx, // core rx bit
    input wire logic       busIdle, // intermission
    input wire logic       hardSync, // hard sync
    input wire logic       rxFrameDone, // frame received
    input wire logic       rxFrameFd, // frame was fd
    input wire logic       rxFormatErr, // classic in fd
    input wire logic       txReqClassic, // classic send
    input wire logic       txRefuse, // refused
    input wire logic       nodePassive, // passive
    input wire logic       esiOut, // esi sent
    input wire logic       tdcActive, // tdc on
    input wire logic [7:0] tdcPosition, // tdc point
    input wire logic       listenOnly // listen mode
);
    // one clock domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_fmt_rx; rxFormatErr |-> rxFrameDone && !rxFrameFd; endproperty
    a_fmt_rx: assert property (p_fmt_rx) else $error("stray format error");
    property p_fmt_tx; (txReqClassic && rxFrameDone && !rxFrameFd) |-> (txRefuse == rxFormatErr); endproperty
    a_fmt_tx: assert property (p_fmt_tx) else $error("policing split");
    property p_listen; listenOnly [*2] |-> canTx && $stable(canTx); endproperty
    a_listen: assert property (p_listen) else $error("listen drove bus");
    property p_txover; (canTx != coreTx) |-> canTx; endproperty
    a_txover: assert property (p_txover) else $error("tx overridden to dominant");
    property p_iloop; (coreRx != canRx) |-> (coreRx == coreTx) && canTx; endproperty
    a_iloop: assert property (p_iloop) else $error("bad rx path");
    property p_hsync; hardSync |-> busIdle && !canRx; endproperty
    a_hsync: assert property (p_hsync) else $error("stray hard sync");
    property p_esi; nodePassive |-> esiOut; endproperty
    a_esi: assert property (p_esi) else $error("esi not passive");
    property p_tdc; !tdcActive |-> tdcPosition == 8'h00; endproperty
    a_tdc: assert property (p_tdc) else $error("tdc point while off");
endmodule // cfc_channel_cfg_properties

bind cfc_channel_cfg cfc_channel_cfg_properties i_props (.*);

// ===== test/cfc_can_bus_model.sv
// can bus behind the transceiver: this node and one other node
`timescale 1ns/1ps
module cfc_can_bus_model (
    input  wire logic canTx,    // node output, 0 dominant
    input  wire logic otherDom, // other node drives dominant
    output logic      canRx     // bus level back to node
);
    // wired-and; idle bus rests recessive through termination
    assign canRx = canTx & ~otherDom;
endmodule // cfc_can_bus_model

// ===== test/test_cfc_channel_cfg.sv
// self-checking bench of the channel configuration block
`timescale 1ns/1ps
module test_cfc_channel_cfg;
    import cfc_pkg::*;
    logic                   clock = 1'b0;
    logic                   sys_rst, clkEn, regWrStb, regRdStb, coreTx, busIdle, otherDom;
    logic                   rxFrameDone, rxFrameFd, txReqClassic, nodePassive, bufEsi, gwInFd, gwInBrs;
    logic                   busOffEv, recovDoneEv, errEv, errIsTx, errIsFd, thlWrite, thlFromQueue, thlPop;
    logic                   irq, canTx, coreRx, tqTick, hardSync, samplePoint, rxFormatErr, txRefuse;
    logic                   esiOut, gwOutFd, gwOutBrs, tdcActive, listenOnly, protoRecovEn;
    wire                    canRx;
    logic [7:0]             regAddr, tdcPosition;
    logic [31:0]            regWrData, regRdData;
    logic [6:0]             tdcMeasured;
    logic [1:0]             modeState;
    logic [NUM_CHAN_EV-1:0] chanEv;
    logic [NUM_TXQ-1:0]     txqSent, txqEmpty, txqFullEv, txqOneRxEv;
    int                     n_mismatch = 0, cmp_count = 0, nHs = 0, cyc = 0, tqLast, tqGap, spLast, spGap;

    cfc_channel_cfg   i_cfc_channel_cfg (.*);
    cfc_can_bus_model i_cfc_can_bus_model (.*);

    always #2 clock = ~clock;

    // pulse spacing and hard sync count
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (hardSync === 1'b1) nHs <= nHs + 1;
        if (tqTick === 1'b1) begin
            tqGap  <= cyc - tqLast;
            tqLast <= cyc;
        end
        if (samplePoint === 1'b1) begin
            spGap  <= cyc - spLast;
            spLast <= cyc;
        end
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clock);
        regWrStb  <= 1'b0;
    endtask

    // data checked in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clock);
        regRdStb <= 1'b0;
        #1 chk(regRdData, e);
    endtask

    task automatic qev(input logic [3:0] s, input logic [3:0] m, input logic [3:0] f);
        @(posedge clock);
        {txqSent, txqEmpty, txqFullEv, txqOneRxEv} <= {s, m, f, f};
        @(posedge clock);
        {txqSent, txqEmpty, txqFullEv, txqOneRxEv} <= '0;
    endtask

    // other node dominant for len cycles
    task automatic glitch(input logic idle, input int len, input int e);
        int n0;
        @(posedge clock);
        n0       = nHs;
        busIdle  <= idle;
        otherDom <= 1'b1;
        tk(len);
        otherDom <= 1'b0;
        tk(4);
        chk(nHs - n0, e);
    endtask

    initial begin
        logic [31:0] bad [2];
        logic [31:0] cf [3];
        logic [3:0]  inp [3];
        logic [11:0] ex [3];
        int          e;
        bad = '{32'h0700_0004, 32'h1001_0000};
        cf  = '{32'h05fc, 32'h056c, 32'h0};
        inp = '{4'h8, 4'h4, 4'hb};
        ex  = '{12'hf08, 12'h305, 12'hc00};
        {regWrStb, regRdStb, busIdle, otherDom, rxFrameDone, rxFrameFd, txReqClassic, nodePassive} = '0;
        {bufEsi, gwInFd, gwInBrs, busOffEv, recovDoneEv, errEv, errIsTx, errIsFd} = '0;
        {thlWrite, thlFromQueue, thlPop, chanEv, txqSent, txqEmpty, txqFullEv, txqOneRxEv} = '0;
        {regAddr, regWrData} = '0;
        tdcMeasured = 7'h03;
        {sys_rst, clkEn, coreTx} = 3'b111;
        tk(8);
        sys_rst <= 1'b0;
        rd(OFS_ARB_TIMING, 32'h0001_0000);
        rd(OFS_CHAN_CFG, 32'h0);
        rd(8'h24, 32'h0);
        wr(OFS_ARB_TIMING, 32'hff3f_03ff);
        rd(OFS_ARB_TIMING, 32'hff3f_03ff);
        // refused timing kept out, error flagged
        foreach (bad[i]) begin
            wr(OFS_ARB_TIMING, bad[i]);
            rd(OFS_ARB_TIMING, 32'hff3f_03ff);
            rd(OFS_MODE, 32'h4);
            wr(OFS_MODE, 32'h4);
        end
        wr(OFS_ARB_TIMING, 32'h0728_0004);
        tk(600);
        chk(tqGap, 5);
        chk(spGap, 250);
        $display("test timing done");
        // configuration outside init mode is ignored
        wr(OFS_MODE, 32'h1);
        wr(OFS_CHAN_CFG, 32'h1);
        rd(OFS_CHAN_CFG, 32'h0);
        rd(OFS_MODE, 32'h5);
        wr(OFS_MODE, 32'h4);
        wr(OFS_CHAN_CFG, 32'h1);
        txReqClassic <= 1'b1;
        rxFrameDone  <= 1'b1;
        #1 chk({txRefuse, rxFormatErr}, 2'b11);
        @(posedge clock);
        rxFrameFd <= 1'b1;
        #1 chk({txRefuse, rxFormatErr}, 2'b10);
        wr(OFS_CHAN_CFG, 32'h0);
        rxFrameFd <= 1'b0;
        #1 chk({txRefuse, rxFormatErr}, 2'b00);
        @(posedge clock);
        {txReqClassic, rxFrameDone} <= 2'b00;
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CHAN_CFG, cf[i]);
            {bufEsi, nodePassive, gwInFd, gwInBrs} <= inp[i];
            #1 chk({gwOutFd, gwOutBrs, esiOut, tdcActive, tdcPosition}, ex[i]);
        end
        $display("test format done");
        coreTx <= 1'b0;
        for (int t = 0; t < 4; t++) begin
            wr(OFS_CHAN_CFG, 32'(t) << 15);
            #1 e = (t == 1 || t == 3);
            chk({canTx, canRx, coreRx, listenOnly}, {e[0], e[0], t == 1, t == 1});
        end
        wr(OFS_CHAN_CFG, 32'h0);
        coreTx <= 1'b1;
        // bus off, recovery, per option
        for (int b = 0; b < 4; b++) begin
            wr(OFS_CHAN_CFG, 32'(b) << 17);
            wr(OFS_MODE, 32'h2);
            #1 chk(protoRecovEn, b != 3);
            @(posedge clock);
            {busOffEv, recovDoneEv} <= 2'b10;
            @(posedge clock);
            {busOffEv, recovDoneEv} <= 2'b01;
            @(posedge clock);
            recovDoneEv <= 1'b0;
            tk(2);
            #1 chk(modeState, (b == 1 || b == 2) ? MODE_CODE_HALT : MODE_CODE_OPER);
            wr(OFS_MODE, 32'h0);
        end
        $display("test modes done");
        // each channel event masked, unmasked, cleared
        for (int k = 0; k < NUM_CHAN_EV; k++) begin
            wr(OFS_IRQ_MASK, 32'h1ffff ^ 32'(1 << k));
            chanEv <= 12'(1 << k);
            @(posedge clock);
            chanEv <= '0;
            #1 chk(irq, 1'b0);
            wr(OFS_IRQ_MASK, 32'h1ffff);
            #1 chk(irq, 1'b1);
            rd(OFS_IRQ_STAT, 32'(1 << k));
            wr(OFS_IRQ_STAT, 32'(1 << k));
            #1 chk(irq, 1'b0);
        end
        wr(OFS_TXQ_CFG, 32'h1333_350d);
        qev(4'h3, 4'h0, 4'hf);
        rd(OFS_IRQ_STAT, 32'h6000);
        qev(4'h1, 4'h1, 4'h0);
        rd(OFS_IRQ_STAT, 32'h7000);
        wr(OFS_IRQ_STAT, 32'h7000);
        // one plain-buffer entry, 24 queued
        wr(OFS_THL_CFG, 32'hf);
        for (int h = 0; h < 25; h++) begin
            @(posedge clock);
            thlWrite     <= 1'b1;
            thlFromQueue <= (h > 0);
            @(posedge clock);
            thlWrite <= 1'b0;
            if (h == 23) rd(OFS_IRQ_STAT, 32'h0);
        end
        rd(OFS_IRQ_STAT, 32'h1_0000);
        rd(OFS_THL_CFG, 32'h18f);
        wr(OFS_IRQ_STAT, 32'h1_0000);
        wr(OFS_THL_CFG, 32'h3);
        thlWrite <= 1'b1;
        @(posedge clock);
        thlWrite <= 1'b0;
        thlPop   <= 1'b1;
        @(posedge clock);
        thlPop <= 1'b0;
        rd(OFS_IRQ_STAT, 32'h1_0000);
        rd(OFS_THL_CFG, 32'h183);
        $display("test interrupts done");
        // one error of each kind per scope
        for (int s = 0; s < 6; s++) begin
            wr(OFS_CHAN_CFG, 32'(s) << 19);
            wr(OFS_ERR_COUNT, 32'h0);
            e = 0;
            for (int c = 0; c < 4; c++) begin
                {errEv, errIsTx, errIsFd} <= {1'b1, 2'(c)};
                @(posedge clock);
                e += int'((s % 3 == 0 || (s % 3 == 1) == (c >= 2) && s % 3 != 0) && (s < 3 || c % 2 == 1));
            end
            errEv <= 1'b0;
            rd(OFS_ERR_COUNT, 32'(e));
        end
        $display("test counting done");
        wr(OFS_CHAN_CFG, 32'h0);
        glitch(1'b0, 1, 0);
        glitch(1'b1, 1, 1);
        wr(OFS_CHAN_CFG, 32'h2);
        glitch(1'b1, 4, 0);
        glitch(1'b1, 12, 1);
        $display("test edge filter done");
        test_done();
    end
endmodule // test_cfc_channel_cfg
